// ---- verilog/via_consts.vh ----
// Constants of the vectored interrupt arbiter
`ifndef VIA_CONSTS_VH
`define VIA_CONSTS_VH
// Register byte offsets
`define VIA_ADR_ENABLE 8'h00
`define VIA_ADR_PEND 8'h04
`define VIA_ADR_CTRL 8'h08
`define VIA_ADR_RESULT 8'h0C
// Control register bit positions
`define VIA_CTRL_GIE 0
`define VIA_CTRL_ACK_BUSY 1
`define VIA_CTRL_VIS_BUSY 2
// Reset values
`define VIA_GIE_RST 1'b0
`define VIA_MASK_RST 14'h0000
// Addresses and vector table layout
`define VIA_ENTRY_ADDR 15'h00FF
`define VIA_TBL_BASE 8'hE0
`define VIA_PAGE_LAST 8'hFF
`define VIA_DEFAULT_SLOT 4'h0
`define VIA_TRAP_SLOT 4'hF
// Instruction cycles of the acknowledge sequence
`define VIA_ACK_CYCLES 3'h7
`endif

// ---- verilog/via_arbiter.v ----
// Vectored interrupt arbiter with acknowledge sequencer and Wishbone registers
//
// Local design decisions: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "via_consts.vh"

// Function
// R1 - Every acknowledge loads the program counter with entry 00FF.
// R2 - Trap wins arbitration; default vector ranks lowest.
// R3 - Trap is non-maskable; each other source has enable and pending flag.
// R4 - Maskable source is active when enabled and pending.
// R5 - Maskable trigger needs enable, global enable, no trap service, instruction start.
// R6 - Maskable requests wait while a trap service routine runs.
// R7 - Highest-ranked qualifying maskable source served first; others stay pending.
// R8 - Reset clears pending flags, enables and global enable.
// R9 - Enabling an already pending source triggers at once.
// R10 - Acknowledge waits for next normally executed instruction; skips come first.
// R11 - Acknowledge clears the global enable.
// R12 - Acknowledge pushes next address, loads 00FF, takes seven instruction cycles.
// R13 - Handler may set global enable for nesting; software guards the stack.
// R14 - Return from interrupt sets global enable; pending requests then serviced.
// R15 - Handler clears its pending flag early to catch repeats.
// R16 - Vector select picks highest active source and jumps through its entry.
// R17 - Table of 16 two-byte vectors at top of the 256-byte block.
// R18 - Vector select at last byte of a block uses the next block.
// R19 - Vector is 15 bits, high byte at lower address.
// R20 - Default at 0yE0, rank rises by two bytes, trap at 0yFE.
// R21 - No active source selects the default vector.
// R22 - Software fills the table with routine addresses, high byte first.
// R23 - Arbitration yields even E0 to FE replacing the counter low byte.
// R24 - Arbitration uses sources sampled in the first vector-select cycle.
// R25 - Trap pending set by trap, hidden, reset cleared, cleared by instruction.
// R26 - Acknowledge and vector select never clear maskable pending flags.
module via_arbiter #(
    parameter NSRC = 14
)(
    // Clock, reset, enable
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Interrupt sources
    input wire [NSRC-1:0] src_evt_i,
    // Instruction sequencer
    input wire instr_start_i,
    input wire skip_i,
    input wire cyc_tick_i,
    input wire trap_fetch_i,
    input wire return_from_irq_i,
    input wire clear_trap_pending_i,
    input wire vector_select_instr_i,
    input wire [14:0] next_pc_i,
    input wire [14:0] vis_pc_i,
    output reg hold_o,
    output reg push_o,
    output reg [14:0] ret_addr_o,
    output reg pc_load_o,
    output reg [14:0] pc_val_o,
    // Program memory read port
    output reg pmem_rd_o,
    output reg [14:0] pmem_addr_o,
    input wire [7:0] pmem_data_i,
    input wire pmem_ack_i
);

    // ************************************************
    // States
    // ************************************************
    localparam ST_IDLE = 4'b0001;
    localparam ST_ACK = 4'b0010;
    localparam ST_VHI = 4'b0100;
    localparam ST_VLO = 4'b1000;

    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg [2:0] cnt_r;
    reg [NSRC-1:0] enable_r;
    reg [NSRC-1:0] pend_r;
    reg [NSRC-1:0] pend_nxt;
    reg global_irq_enable_r;
    reg gie_nxt;
    reg trap_pending_flag_r;
    reg trap_nxt;
    reg [6:0] vec_hi_r;
    reg [7:0] last_low_r;
    reg [14:0] last_target_r;
    reg [3:0] win_slot;
    reg [31:0] rd_data;
    integer i;

    wire bus_req;
    wire bus_wr;
    wire [31:0] byte_mask;
    wire [NSRC-1:0] wmask;
    wire [NSRC-1:0] active;
    wire maskable_go;
    wire trap_go;
    wire vis_go;
    wire [7:0] low_byte;
    wire [6:0] tbl_page;

    // ************************************************
    // Register bus
    // ************************************************
    assign bus_req = wb_cyc_i & wb_stb_i;
    // Write lands at the edge where the master samples ack
    assign bus_wr = bus_req & wb_we_i & wb_ack_o;
    assign byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                        {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wmask = byte_mask[NSRC-1:0];

    always @*
    begin
        rd_data = 32'h00000000;
        case (wb_adr_i)
            `VIA_ADR_ENABLE:
                rd_data[NSRC-1:0] = enable_r;
            `VIA_ADR_PEND:
                rd_data[NSRC-1:0] = pend_r;
            `VIA_ADR_CTRL:
            begin
                rd_data[`VIA_CTRL_GIE] = global_irq_enable_r;
                rd_data[`VIA_CTRL_ACK_BUSY] = state_r[1];
                rd_data[`VIA_CTRL_VIS_BUSY] = state_r[2] | state_r[3];
            end
            `VIA_ADR_RESULT:
                rd_data[22:0] = {last_target_r, last_low_r};
            default:
                rd_data = 32'h00000000;
        endcase
    end

    // ************************************************
    // Arbitration
    // ************************************************
    // R4 active sources
    assign active = enable_r & pend_r;

    // R2 R7 R16 R21 rank order, trap on top
    always @*
    begin
        win_slot = `VIA_DEFAULT_SLOT;
        for (i = 0; i < NSRC; i = i + 1)
        begin
            if (active[i])
                win_slot = i[3:0] + 4'h1;
        end
        if (trap_pending_flag_r)
            win_slot = `VIA_TRAP_SLOT;
    end

    // R20 R23 even low byte from E0 to FE
    assign low_byte = `VIA_TBL_BASE + {3'b000, win_slot, 1'b0};
    // R17 R18 table page, next block when at last byte
    assign tbl_page = (vis_pc_i[7:0] == `VIA_PAGE_LAST) ?
                      vis_pc_i[14:8] + 7'h01 : vis_pc_i[14:8];

    // ************************************************
    // Triggers
    // ************************************************
    // R5 R6 R9 R10 maskable trigger at normal instruction start
    assign maskable_go = instr_start_i & ~skip_i & global_irq_enable_r
                         & ~trap_pending_flag_r & (|active)
                         & state_r[0];
    // Trap ignores skip and global enable, since the trap opcode is the fetched instruction
    // R3 trap cannot be masked
    assign trap_go = instr_start_i & trap_fetch_i & state_r[0];
    // R24 sample sources in first vector-select cycle
    assign vis_go = vector_select_instr_i & state_r[0]
                    & ~trap_go & ~maskable_go;

    // ************************************************
    // Next state
    // ************************************************
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
            begin
                if (trap_go | maskable_go)
                    state_nxt = ST_ACK;
                else if (vis_go)
                    state_nxt = ST_VHI;
            end
            ST_ACK:
            begin
                // R12 busy until seventh cycle
                if (cyc_tick_i && cnt_r == `VIA_ACK_CYCLES - 3'h1)
                    state_nxt = ST_IDLE;
            end
            ST_VHI:
            begin
                if (pmem_ack_i)
                    state_nxt = ST_VLO;
            end
            ST_VLO:
            begin
                if (pmem_ack_i)
                    state_nxt = ST_IDLE;
            end
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    // ************************************************
    // Flag updates
    // ************************************************
    always @*
    begin
        // R3 R15 R26 software writes, events set and win over clears
        pend_nxt = pend_r;
        if (bus_wr && wb_adr_i == `VIA_ADR_PEND)
            pend_nxt = (wb_dat_i[NSRC-1:0] & wmask) | (pend_r & ~wmask);
        pend_nxt = pend_nxt | src_evt_i;

        // R11 acknowledge clears global enable
        gie_nxt = global_irq_enable_r;
        if (trap_go | maskable_go)
            gie_nxt = 1'b0;
        // R13 software may set it for nesting
        if (bus_wr && wb_adr_i == `VIA_ADR_CTRL && wb_sel_i[0])
            gie_nxt = wb_dat_i[`VIA_CTRL_GIE];
        // R14 return sets global enable
        if (return_from_irq_i)
            gie_nxt = 1'b1;

        // R25 trap flag set wins over the clear instruction
        trap_nxt = trap_pending_flag_r;
        if (clear_trap_pending_i)
            trap_nxt = 1'b0;
        if (trap_go)
            trap_nxt = 1'b1;
    end

    // ************************************************
    // Per-source flags
    // ************************************************
    // Reset pattern sized to the source count
    localparam [NSRC-1:0] MASK_RST = `VIA_MASK_RST;
    genvar g;

    generate
        for (g = 0; g < NSRC; g = g + 1)
        begin : g_src
            wire en_wr;

            // R3 R9 lane-masked enable write, lands with the bus ack
            assign en_wr = bus_wr & (wb_adr_i == `VIA_ADR_ENABLE) & wmask[g];

            always @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    // R8 enable and pending cleared
                    enable_r[g] <= MASK_RST[g];
                    pend_r[g] <= MASK_RST[g];
                end
                else if (ce_i)
                begin
                    // R3 R26 only events and software move the flag
                    pend_r[g] <= pend_nxt[g];
                    if (en_wr)
                        enable_r[g] <= wb_dat_i[g];
                end
            end
        end
    endgenerate

    // ************************************************
    // Registers
    // ************************************************
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r <= ST_IDLE;
            cnt_r <= 3'h0;
            // R8 clear global enable
            global_irq_enable_r <= `VIA_GIE_RST;
            trap_pending_flag_r <= 1'b0;
            vec_hi_r <= 7'h00;
            last_low_r <= 8'h00;
            last_target_r <= 15'h0000;
            wb_dat_o <= 32'h00000000;
            wb_ack_o <= 1'b0;
            hold_o <= 1'b0;
            push_o <= 1'b0;
            ret_addr_o <= 15'h0000;
            pc_load_o <= 1'b0;
            pc_val_o <= 15'h0000;
            pmem_rd_o <= 1'b0;
            pmem_addr_o <= 15'h0000;
        end
        else if (ce_i)
        begin
            state_r <= state_nxt;
            global_irq_enable_r <= gie_nxt;
            trap_pending_flag_r <= trap_nxt;
            hold_o <= ~state_nxt[0];
            push_o <= 1'b0;
            pc_load_o <= 1'b0;

            // Unmapped reads return zero, writes are dropped
            // Ack lasts one cycle, so a strobe held on is never acked twice in a row
            wb_ack_o <= bus_req & ~wb_ack_o;
            wb_dat_o <= rd_data;

            case (state_r)
                ST_IDLE:
                begin
                    cnt_r <= 3'h0;
                    if (trap_go | maskable_go)
                    begin
                        // R12 return address latched at acknowledge
                        ret_addr_o <= next_pc_i;
                    end
                    else if (vis_go)
                    begin
                        // R16 R19 fetch high byte of chosen vector
                        last_low_r <= low_byte;
                        pmem_addr_o <= {tbl_page, low_byte};
                        pmem_rd_o <= 1'b1;
                    end
                end
                ST_ACK:
                begin
                    if (cyc_tick_i)
                    begin
                        cnt_r <= cnt_r + 3'h1;
                        // R12 push on first instruction cycle
                        if (cnt_r == 3'h0)
                            push_o <= 1'b1;
                        // R1 R12 jump to entry on seventh cycle
                        if (cnt_r == `VIA_ACK_CYCLES - 3'h1)
                        begin
                            pc_val_o <= `VIA_ENTRY_ADDR;
                            pc_load_o <= 1'b1;
                        end
                    end
                end
                ST_VHI:
                begin
                    if (pmem_ack_i)
                    begin
                        // R19 high byte sits at the lower address
                        vec_hi_r <= pmem_data_i[6:0];
                        pmem_addr_o <= pmem_addr_o + 15'h0001;
                    end
                end
                ST_VLO:
                begin
                    if (pmem_ack_i)
                    begin
                        pmem_rd_o <= 1'b0;
                        pc_val_o <= {vec_hi_r, pmem_data_i};
                        last_target_r <= {vec_hi_r, pmem_data_i};
                        pc_load_o <= 1'b1;
                    end
                end
                default:
                    cnt_r <= 3'h0;
            endcase
        end
    end

endmodule // via_arbiter

// ---- test/via_pmem_model.sv ----
// Program memory model serving vector table reads
`timescale 1ns/1ns
module via_pmem_model (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Read port
    input wire rd_i,
    input wire [14:0] addr_i,
    input wire [3:0] dly_i,
    output reg [7:0] data_o,
    output reg ack_o
);
    reg [3:0] cnt_r;
    always @(posedge clk_i)
    begin
        ack_o <= 1'b0;
        cnt_r <= 4'h0;
        data_o <= rst_i ? 8'h00 : ~data_o;
        if (rd_i && !ack_o && !rst_i)
            cnt_r <= cnt_r + 4'h1;
        if (rd_i && !ack_o && !rst_i && cnt_r == dly_i)
        begin
            ack_o <= 1'b1;
            data_o <= addr_i[0] ? addr_i[7:0] : {1'b1, addr_i[14:8]};
        end
    end
endmodule // via_pmem_model

// ---- test/via_arbiter_properties.sv ----
// Checker of the vectored interrupt arbiter
`timescale 1ns/1ns
module via_arbiter_chk (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Sequencer
    input wire instr_start_i,
    input wire skip_i,
    input wire trap_fetch_i,
    input wire cyc_tick_i,
    input wire vector_select_instr_i,
    input wire [14:0] vis_pc_i,
    input wire hold_o,
    input wire push_o,
    input wire pc_load_o,
    input wire [14:0] pc_val_o,
    // Program memory
    input wire pmem_rd_o,
    input wire [14:0] pmem_addr_o,
    input wire [7:0] pmem_data_i,
    input wire pmem_ack_i
);
    reg [2:0] tk_r;
    reg [6:0] hi_r;
    reg [6:0] pg_r;
    // Vector fetch gets no ticks, so the count is the acknowledge's
    always @(posedge clk_i)
    begin
        if (rst_i || !hold_o)
            tk_r <= 3'h0;
        else if (cyc_tick_i)
            tk_r <= tk_r + 3'h1;
        if (pmem_ack_i && !pmem_addr_o[0])
            hi_r <= pmem_data_i[6:0];
        pg_r <= vis_pc_i[14:8] + {6'h00, &vis_pc_i[7:0]};
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ENTRY: assert property (pc_load_o && !$past(pmem_rd_o) |->
        pc_val_o == 15'h00FF && tk_r == 3'h7) else $error("entry");
    AST_PUSH: assert property (push_o |-> hold_o && tk_r == 3'h1)
        else $error("push");
    AST_SKIP: assert property (instr_start_i && skip_i && !trap_fetch_i && !hold_o
        |=> !hold_o) else $error("skip");
    AST_EVEN: assert property ($rose(pmem_rd_o) |->
        pmem_addr_o[7:5] == 3'h7 && !pmem_addr_o[0]) else $error("even");
    AST_PAGE: assert property (vector_select_instr_i && !hold_o |=> pmem_rd_o &&
        pmem_addr_o[14:8] == pg_r) else $error("page");
    AST_ORDER: assert property (pmem_ack_i && pmem_rd_o && !pmem_addr_o[0] |=>
        pmem_rd_o && pmem_addr_o == $past(pmem_addr_o) + 15'h1) else $error("order");
    AST_PAIR: assert property (pmem_ack_i && pmem_rd_o && pmem_addr_o[0] |=>
        pc_load_o && pc_val_o == {hi_r, $past(pmem_data_i)}) else $error("pair");
    AST_RST: assert property ($fell(rst_i) |-> !hold_o && !pmem_rd_o && !pc_load_o)
        else $error("reset");
endmodule // via_arbiter_chk
bind via_arbiter via_arbiter_chk u_via_arbiter_chk (.clk_i(clk_i), .rst_i(rst_i),
    .instr_start_i(instr_start_i), .skip_i(skip_i), .trap_fetch_i(trap_fetch_i),
    .cyc_tick_i(cyc_tick_i), .vector_select_instr_i(vector_select_instr_i),
    .vis_pc_i(vis_pc_i), .hold_o(hold_o), .push_o(push_o), .pc_load_o(pc_load_o),
    .pc_val_o(pc_val_o), .pmem_rd_o(pmem_rd_o), .pmem_addr_o(pmem_addr_o),
    .pmem_data_i(pmem_data_i), .pmem_ack_i(pmem_ack_i));

// ---- test/via_arbiter_bench.sv ----
// Self-checking bench of the vectored interrupt arbiter
`timescale 1ns/1ns
module via_arbiter_bench;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg cyc, stb, we;
    reg [6:0] ctl;
    reg [7:0] adr;
    reg [31:0] dat, rd;
    reg [13:0] evt;
    reg [14:0] npc, vpc;
    reg [3:0] dly;
    reg ce = 1'b1;
    wire hold, pcl, prd, pack, wack;
    wire [14:0] ret, pcv, padr;
    wire [7:0] pdat;
    wire [31:0] wdo;
    integer error_cnt = 0;
    integer samples_checked = 0;
    integer i, n;
    always #4 clk_i = ~clk_i;
    via_arbiter u_via_arbiter (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(wack), .src_evt_i(evt),
        .instr_start_i(ctl[0]), .skip_i(ctl[1]), .cyc_tick_i(ctl[2]), .trap_fetch_i(ctl[3]),
        .return_from_irq_i(ctl[4]), .clear_trap_pending_i(ctl[5]),
        .vector_select_instr_i(ctl[6]), .next_pc_i(npc), .vis_pc_i(vpc), .hold_o(hold),
        .push_o(), .ret_addr_o(ret), .pc_load_o(pcl), .pc_val_o(pcv), .pmem_rd_o(prd),
        .pmem_addr_o(padr), .pmem_data_i(pdat), .pmem_ack_i(pack));
    via_pmem_model u_via_pmem_model (.clk_i(clk_i), .rst_i(rst_i), .rd_i(prd),
        .addr_i(padr), .dly_i(dly), .data_o(pdat), .ack_o(pack));
    task chk(input [31:0] nm, input [31:0] got, input [31:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp)
            $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
        error_cnt = error_cnt + (got !== exp);
    end
    endtask
    task wb(input w, input [7:0] a, input [31:0] d);
    begin
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        @(posedge clk_i);
        for (n = 0; wack !== 1'b1 && n < 20; n = n + 1)
            @(posedge clk_i);
        if (wack !== 1'b1)
        begin
            $display("[FAIL] ack expected 1 seen %b", wack);
            error_cnt = error_cnt + 1;
        end
        rd = wdo;
        {cyc, stb} <= 2'b00;
    end
    endtask
    task pulse(input [6:0] m);
    begin
        @(posedge clk_i);
        ctl <= m;
        @(posedge clk_i);
        ctl <= 7'h00;
    end
    endtask
    task wpc(input [14:0] e);
    begin
        for (n = 0; pcl !== 1'b1 && n < 60; n = n + 1)
            @(negedge clk_i);
        if (pcl !== 1'b1)
        begin
            $display("[FAIL] pc_load expected 1 seen %b", pcl);
            error_cnt = error_cnt + 1;
        end
        chk("pc", pcv, e);
    end
    endtask
    task ack(input [6:0] m, input e);
    begin
        pulse(m);
        @(negedge clk_i);
        chk("hold", hold, e);
        if (e)
        begin
            repeat (7) pulse(7'h04);
            wpc(15'h00FF);
            chk("ret", ret, npc);
        end
    end
    endtask
    task wrap_up;
    begin
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    initial
    begin
        #200000;
        error_cnt = error_cnt + 1;
        wrap_up;
    end
    initial
    begin
        {cyc, stb, we, ctl, adr, dat, evt, vpc, dly} = '0;
        npc = 15'h5A5A;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 20; i = i + 4)
        begin
            wb(1'b0, i[7:0], 32'h0);
            chk("rst", rd, 32'h0);
        end
        $display("reset test done");
        evt <= 14'h3FFF;
        wb(1'b1, 8'h08, 32'h1);
        evt <= 14'h0000;
        ack(7'h01, 1'b0);
        wb(1'b1, 8'h00, 32'h8);
        ack(7'h03, 1'b0);
        ack(7'h01, 1'b1);
        wb(1'b0, 8'h08, 32'h0);
        chk("gie", rd[0], 1'b0);
        ack(7'h01, 1'b0);
        pulse(7'h10);
        wb(1'b0, 8'h08, 32'h0);
        chk("gie", rd[0], 1'b1);
        $display("acknowledge test done");
        wb(1'b1, 8'h00, 32'h3FFF);
        // Walk down the ranks; odd ranks sit at a block end
        for (i = 13; i >= -1; i = i - 1)
        begin
            vpc <= {i[6:0], i[0] ? 8'hFF : 8'h20};
            dly <= i[3:0];
            pulse(7'h40);
            wpc({vpc[14:8] + {6'h00, &vpc[7:0]}, 8'hE1 + {i[6:0] + 7'h1, 1'b0}});
            wb(1'b0, 8'h04, 32'h0);
            chk("pend", rd, (32'h1 << (i + 1)) - 32'h1);
            // Handler clears its own flag; the next pass reads it back
            wb(1'b1, 8'h04, ((32'h1 << (i + 1)) - 32'h1) >> 1);
        end
        $display("vector test done");
        ack(7'h09, 1'b1);
        wb(1'b1, 8'h08, 32'h1);
        wb(1'b0, 8'h08, 32'h0);
        chk("gie", rd[0], 1'b1);
        evt <= 14'h0020;
        ack(7'h01, 1'b0);
        vpc <= 15'h0150;
        pulse(7'h40);
        wpc(15'h01FF);
        pulse(7'h20);
        // Frozen by the clock enable, a due acknowledge must not start
        ce <= 1'b0;
        ack(7'h01, 1'b0);
        @(posedge clk_i);
        ce <= 1'b1;
        ack(7'h01, 1'b1);
        $display("trap test done");
        wrap_up;
    end
endmodule // via_arbiter_bench
